// [core/pamx_mux.sv]
// Notes on behaviour
// - Pin 15 select at bits 31:30; 00 is general I/O and reset value.
// - Pin 15 code 01 follows direction: input feeds trip four, output drives grant.
// - Grant output goes low once the memory interface grants a pending hold.
// - While granted, all memory interface buses and strobes are high impedance.
// - Grant is withdrawn when the outside party releases its hold request.
// - Pin 15 code 10 routes the pin to serial port B receive.
// - Pin 15 code 11 is buffered port B frame sync; reserved without that port.
// - Pin 14 select at bits 29:28; 00 is general I/O and reset value.
// - Pin 14 code 01 is input for trip three and active-low hold request.
// - Hold-disable bit set stops the request pin from tri-stating the bus.
// - Bus is released only after current and pending accesses finish.
// - Trip inputs are ignored by the modulator until software enables them.
// - Pin 14 code 10 is serial B transmit; 11 buffered port B clock.
// - Pin 13 select at bits 27:26; 00 is general I/O and reset value.
// - Reserved codes give undefined pin state; here the pin is left undriven.
// - Mux register takes writes only while the protected write unlock is active.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pamx_consts.svh"

module pamx_mux #(
    parameter int HAS_BUF_PORT_B = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [`PAMX_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic protected_write_unlock,
    input wire logic pin15_in,
    output pamx_pkg::pamx_pin_s pin15_drv,
    input wire logic pin14_in,
    output pamx_pkg::pamx_pin_s pin14_drv,
    input wire logic pin13_in,
    output pamx_pkg::pamx_pin_s pin13_drv,
    output logic trip_zone_three_n,
    output logic trip_zone_four_n,
    input wire logic serial_b_transmit,
    output logic serial_b_receive,
    input wire pamx_pkg::pamx_pin_s buffered_port_b_tx_frame_sync_drv,
    output logic buffered_port_b_tx_frame_sync_in,
    input wire pamx_pkg::pamx_pin_s buffered_port_b_tx_clock_drv,
    output logic buffered_port_b_tx_clock_in,
    input wire logic xmi_access_busy,
    input wire logic xmi_access_pending,
    output logic xmi_hold_draining,
    output logic xmi_bus_tristate,
    output logic [2:0] gpio_in_level
);

    // Refuse a variant flag the logic cannot serve
    if (HAS_BUF_PORT_B != 0 && HAS_BUF_PORT_B != 1) begin : g_chk
        $error("HAS_BUF_PORT_B must be 0 or 1");
    end

    localparam logic HAS_BP = (HAS_BUF_PORT_B != 0);

    logic [31:0] mux_q;
    logic [2:0] dir_q;
    logic [2:0] ctrl_q;
    logic [2:0] data_q;
    logic [31:0] rdata_q;
    pamx_pkg::pamx_hold_e hold_q;
    pamx_pkg::pamx_hold_e hold_d;
    pamx_pkg::pamx_sel_t sel15;
    pamx_pkg::pamx_sel_t sel14;
    pamx_pkg::pamx_sel_t sel13;
    logic dir15;
    logic hold_req;
    logic rsvd_sel;
    logic grant_n;
    pamx_pkg::pamx_pin_s p15_d;
    pamx_pkg::pamx_pin_s p14_d;
    pamx_pkg::pamx_pin_s p13_d;
    pamx_pkg::pamx_pin_s p15_q;
    pamx_pkg::pamx_pin_s p14_q;
    pamx_pkg::pamx_pin_s p13_q;
    logic tz3_q;
    logic tz4_q;
    logic rx_q;
    logic fs_in_q;
    logic ck_in_q;
    logic tri_q;
    logic drain_q;
    logic [2:0] lvl_q;

    // Field views
    assign sel15 = mux_q[`PAMX_P15_LSB +: 2];
    assign sel14 = mux_q[`PAMX_P14_LSB +: 2];
    assign sel13 = mux_q[`PAMX_P13_LSB +: 2];
    assign dir15 = dir_q[2];

    // Mux register, writable only behind the unlock
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mux_q <= `PAMX_MUX_RST;
        end else if (reg_wr && reg_addr == `PAMX_OFS_MUX && protected_write_unlock) begin
            mux_q <= reg_wdata;
        end
    end

    // Direction, control and output data registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dir_q <= `PAMX_DIR_RST;
            ctrl_q <= `PAMX_CTRL_RST;
            data_q <= `PAMX_DATA_RST;
        end else if (reg_wr) begin
            if (reg_addr == `PAMX_OFS_DIR) begin
                dir_q <= reg_wdata[`PAMX_PIN_MSB:`PAMX_PIN_LSB];
            end
            if (reg_addr == `PAMX_OFS_CTRL) begin
                ctrl_q <= reg_wdata[2:0];
            end
            if (reg_addr == `PAMX_OFS_DATA) begin
                data_q <= reg_wdata[`PAMX_PIN_MSB:`PAMX_PIN_LSB];
            end
        end
    end

    // Request from pin 14, unless software has masked it off
    assign hold_req = (sel14 == `PAMX_SEL_ALT1) && !pin14_in
        && !ctrl_q[`PAMX_CTRL_HOLD_DIS];

    // Hold handshake next state
    always_comb begin
        hold_d = hold_q;
        case (hold_q)
            pamx_pkg::hold_idle: begin
                if (hold_req) begin
                    hold_d = pamx_pkg::hold_drain;
                end
            end
            pamx_pkg::hold_drain: begin
                // Wait out the access in flight and anything queued
                if (!hold_req) begin
                    hold_d = pamx_pkg::hold_idle;
                end else if (!xmi_access_busy && !xmi_access_pending) begin
                    hold_d = pamx_pkg::hold_granted;
                end
            end
            pamx_pkg::hold_granted: begin
                if (!hold_req) begin
                    hold_d = pamx_pkg::hold_idle;
                end
            end
            default: begin
                hold_d = pamx_pkg::hold_idle;
            end
        endcase
    end

    // Hold handshake state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hold_q <= pamx_pkg::hold_idle;
        end else begin
            hold_q <= hold_d;
        end
    end

    assign grant_n = (hold_q != pamx_pkg::hold_granted);

    // Reserved codes: undriven pin is our safe choice for an undefined state
    assign rsvd_sel = (!HAS_BP && sel15 == `PAMX_SEL_ALT3)
        || (!HAS_BP && sel14 == `PAMX_SEL_ALT3)
        || (sel13 != `PAMX_SEL_GPIO);

    // Pin 15 drive
    always_comb begin
        p15_d = '0;
        case (sel15)
            `PAMX_SEL_GPIO: begin
                p15_d.o = data_q[2];
                p15_d.oe = dir_q[2];
            end
            `PAMX_SEL_ALT1: begin
                // Output direction carries the grant, input leaves the pin free
                p15_d.o = grant_n;
                p15_d.oe = dir15;
            end
            `PAMX_SEL_ALT2: begin
                p15_d = '0;
            end
            `PAMX_SEL_ALT3: begin
                if (HAS_BP) begin
                    p15_d = buffered_port_b_tx_frame_sync_drv;
                end
            end
            default: begin
                p15_d = '0;
            end
        endcase
    end

    // Pin 14 drive
    always_comb begin
        p14_d = '0;
        case (sel14)
            `PAMX_SEL_GPIO: begin
                p14_d.o = data_q[1];
                p14_d.oe = dir_q[1];
            end
            `PAMX_SEL_ALT1: begin
                p14_d = '0;
            end
            `PAMX_SEL_ALT2: begin
                p14_d.o = serial_b_transmit;
                p14_d.oe = 1'b1;
            end
            `PAMX_SEL_ALT3: begin
                if (HAS_BP) begin
                    p14_d = buffered_port_b_tx_clock_drv;
                end
            end
            default: begin
                p14_d = '0;
            end
        endcase
    end

    // Pin 13: only general I/O is built, other codes leave it undriven
    always_comb begin
        p13_d = '0;
        if (sel13 == `PAMX_SEL_GPIO) begin
            p13_d.o = data_q[0];
            p13_d.oe = dir_q[0];
        end
    end

    // Registered pin and peripheral outputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            p15_q <= '0;
            p14_q <= '0;
            p13_q <= '0;
            tz3_q <= 1'b1;
            tz4_q <= 1'b1;
            rx_q <= 1'b1;
            fs_in_q <= 1'b0;
            ck_in_q <= 1'b0;
            tri_q <= 1'b0;
            drain_q <= 1'b0;
            lvl_q <= 3'h0;
        end else begin
            p15_q <= p15_d;
            p14_q <= p14_d;
            p13_q <= p13_d;
            // Trips read high unless routed and enabled
            tz3_q <= !(ctrl_q[`PAMX_CTRL_TZ3_EN] && sel14 == `PAMX_SEL_ALT1
                && !pin14_in);
            tz4_q <= !(ctrl_q[`PAMX_CTRL_TZ4_EN] && sel15 == `PAMX_SEL_ALT1
                && !dir15 && !pin15_in);
            rx_q <= (sel15 == `PAMX_SEL_ALT2) ? pin15_in : 1'b1;
            fs_in_q <= HAS_BP && sel15 == `PAMX_SEL_ALT3 && pin15_in;
            ck_in_q <= HAS_BP && sel14 == `PAMX_SEL_ALT3 && pin14_in;
            tri_q <= (hold_q == pamx_pkg::hold_granted);
            drain_q <= (hold_q == pamx_pkg::hold_drain);
            lvl_q <= {pin15_in, pin14_in, pin13_in};
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= 32'h0000_0000;
            if (reg_rd) begin
                case (reg_addr)
                    `PAMX_OFS_MUX: rdata_q <= mux_q;
                    `PAMX_OFS_DIR: rdata_q[`PAMX_PIN_MSB:`PAMX_PIN_LSB] <= dir_q;
                    `PAMX_OFS_CTRL: rdata_q[2:0] <= ctrl_q;
                    `PAMX_OFS_DATA: rdata_q[`PAMX_PIN_MSB:`PAMX_PIN_LSB] <= data_q;
                    `PAMX_OFS_STAT: begin
                        rdata_q[`PAMX_STAT_GRANT] <= (hold_q == pamx_pkg::hold_granted);
                        rdata_q[`PAMX_STAT_REQ] <= hold_req;
                        rdata_q[`PAMX_STAT_DRAIN] <= (hold_q == pamx_pkg::hold_drain);
                        rdata_q[`PAMX_STAT_RSVD] <= rsvd_sel;
                        rdata_q[`PAMX_PIN_MSB:`PAMX_PIN_LSB] <= lvl_q;
                    end
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign pin15_drv = p15_q;
    assign pin14_drv = p14_q;
    assign pin13_drv = p13_q;
    assign trip_zone_three_n = tz3_q;
    assign trip_zone_four_n = tz4_q;
    assign serial_b_receive = rx_q;
    assign buffered_port_b_tx_frame_sync_in = fs_in_q;
    assign buffered_port_b_tx_clock_in = ck_in_q;
    assign xmi_bus_tristate = tri_q; // outside master relies on this
    assign xmi_hold_draining = drain_q;
    assign gpio_in_level = lvl_q;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_mux_reset_gpio: assert property (disable iff (1'b0) !nrst |=> mux_q == `PAMX_MUX_RST)
        else $error("mux register not cleared by reset");
    a_pin15_grant_drive: assert property (sel15 == `PAMX_SEL_ALT1 && dir15 && $stable(mux_q)
        |=> pin15_drv.oe && pin15_drv.o == $past(grant_n))
        else $error("pin 15 does not drive the grant");
    // Grant shows the cycle after drain ends; the bus floats one cycle later
    a_grant_goes_low: assert property (hold_q == pamx_pkg::hold_drain && hold_req
        && !xmi_access_busy && !xmi_access_pending |=> !grant_n ##1 xmi_bus_tristate)
        else $error("grant not given after drain");
    a_bus_tristate: assert property (hold_q == pamx_pkg::hold_granted |=> xmi_bus_tristate)
        else $error("bus not tri-stated while granted");
    a_grant_release: assert property (hold_q == pamx_pkg::hold_granted && !hold_req
        |=> grant_n ##1 !xmi_bus_tristate)
        else $error("grant kept after request released");
    a_rx_route: assert property (sel15 == `PAMX_SEL_ALT2 |=> serial_b_receive == $past(pin15_in))
        else $error("serial receive not routed");
    // Frame sync drive passes through when the port exists, else the pin floats
    a_fs_route: assert property (sel15 == `PAMX_SEL_ALT3
        |=> HAS_BP ? pin15_drv == $past(buffered_port_b_tx_frame_sync_drv) : !pin15_drv.oe)
        else $error("frame sync code drives pin wrongly");
    a_hold_disable: assert property (ctrl_q[`PAMX_CTRL_HOLD_DIS] && hold_q == pamx_pkg::hold_idle
        |=> hold_q == pamx_pkg::hold_idle)
        else $error("hold taken while disabled");
    a_req_input_only: assert property (sel14 == `PAMX_SEL_ALT1 |=> !pin14_drv.oe)
        else $error("request pin driven");
    a_drain_wait: assert property (hold_q == pamx_pkg::hold_drain
        && (xmi_access_busy || xmi_access_pending) |=> hold_q != pamx_pkg::hold_granted)
        else $error("bus released with access open");
    a_trip_ignored: assert property (!ctrl_q[`PAMX_CTRL_TZ3_EN] |=> trip_zone_three_n)
        else $error("trip three acted while disabled");
    a_trip4_ignored: assert property (!ctrl_q[`PAMX_CTRL_TZ4_EN] |=> trip_zone_four_n)
        else $error("trip four acted while disabled");
    a_tx_route: assert property (sel14 == `PAMX_SEL_ALT2
        |=> pin14_drv.oe && pin14_drv.o == $past(serial_b_transmit))
        else $error("serial transmit not routed");
    a_rsvd_quiet: assert property (sel13 != `PAMX_SEL_GPIO |=> !pin13_drv.oe)
        else $error("reserved pin 13 code drives pin");
    a_locked_write: assert property (reg_wr && reg_addr == `PAMX_OFS_MUX && !protected_write_unlock
        |=> $stable(mux_q))
        else $error("locked mux write took effect");

    c_hold_granted: cover property (hold_q == pamx_pkg::hold_drain ##1 hold_q == pamx_pkg::hold_granted);
    c_drain_waits: cover property (hold_q == pamx_pkg::hold_drain && xmi_access_busy);
    c_rx_routed: cover property (sel15 == `PAMX_SEL_ALT2 && !pin15_in);
    c_locked_write: cover property (reg_wr && reg_addr == `PAMX_OFS_MUX && !protected_write_unlock);

endmodule // pamx_mux

`default_nettype wire

// [core/pamx_consts.svh]
`ifndef PAMX_CONSTS_SVH
`define PAMX_CONSTS_SVH

// Register byte offsets on the plain register port
`define PAMX_AW 8
`define PAMX_OFS_MUX 8'h00
`define PAMX_OFS_DIR 8'h04
`define PAMX_OFS_CTRL 8'h08
`define PAMX_OFS_DATA 8'h0C
`define PAMX_OFS_STAT 8'h10

// Reset values
`define PAMX_MUX_RST 32'h0000_0000
`define PAMX_DIR_RST 3'h0
`define PAMX_CTRL_RST 3'h0
`define PAMX_DATA_RST 3'h0

// Select field positions in the mux register
`define PAMX_P15_LSB 30
`define PAMX_P14_LSB 28
`define PAMX_P13_LSB 26

// Select codes
`define PAMX_SEL_GPIO 2'h0
`define PAMX_SEL_ALT1 2'h1
`define PAMX_SEL_ALT2 2'h2
`define PAMX_SEL_ALT3 2'h3

// Direction and data registers keep pins 15..13 at their own bit numbers
`define PAMX_PIN_LSB 13
`define PAMX_PIN_MSB 15

// Control register bits
`define PAMX_CTRL_HOLD_DIS 0
`define PAMX_CTRL_TZ3_EN 1
`define PAMX_CTRL_TZ4_EN 2

// Status register bits
`define PAMX_STAT_GRANT 0
`define PAMX_STAT_REQ 1
`define PAMX_STAT_DRAIN 2
`define PAMX_STAT_RSVD 3

`endif

// [core/pamx_pkg.sv]
`default_nettype none

package pamx_pkg;

    // Select code of one pin
    typedef logic [1:0] pamx_sel_t;

    // Drive of one two-way pin
    typedef struct packed {
        logic o;
        logic oe;
    } pamx_pin_s;

    // Bus hold handshake
    typedef enum logic [1:0] {
        hold_idle,
        hold_drain,
        hold_granted
    } pamx_hold_e;

endpackage

`default_nettype wire

// [verification/pamx_hold_master.sv]
`timescale 1ns/100ps
`default_nettype none

// Outside master that borrows the memory bus through the hold handshake
module pamx_hold_master (
    input wire logic clk,
    input wire logic nrst,
    input wire logic want_bus,
    input wire logic grant_n,
    output logic hold_req_n,
    output logic ext_bus_en
);
    // Request follows the wish; dropping it is how the grant gets withdrawn
    always_ff @(posedge clk) begin
        if (!nrst) hold_req_n <= 1'b1;
        else hold_req_n <= !want_bus;
    end

    // Never drive the shared bus unless granted, or two drivers would fight
    always_ff @(posedge clk) begin
        if (!nrst) ext_bus_en <= 1'b0;
        else ext_bus_en <= want_bus && !grant_n;
    end
endmodule // pamx_hold_master
`default_nettype wire

// [verification/pamx_mux_test.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pamx_consts.svh"

module pamx_mux_test;
    logic clk, nrst, reg_wr, reg_rd, unlock, p15_ext, p13_ext, sb_tx, busy, pend, want;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val, mdl_mux;
    pamx_pkg::pamx_pin_s p15_drv, p14_drv, p13_drv, fs_drv, ck_drv;
    logic tz3_n, tz4_n, sb_rx, fs_in, ck_in, draining, tristate, hold_req_n, ext_bus_en;
    logic [2:0] gpio_lvl, gp_dir, gp_dat;
    wire logic lvl15, lvl14, lvl13;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'hce30_5fd6;

    // Wire levels: a driving pin wins, else the outside world
    assign lvl15 = p15_drv.oe ? p15_drv.o : p15_ext;
    assign lvl14 = p14_drv.oe ? p14_drv.o : hold_req_n;
    assign lvl13 = p13_drv.oe ? p13_drv.o : p13_ext;

    pamx_mux u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .protected_write_unlock(unlock), .pin15_in(lvl15),
        .pin15_drv(p15_drv), .pin14_in(lvl14), .pin14_drv(p14_drv), .pin13_in(lvl13), .pin13_drv(p13_drv),
        .trip_zone_three_n(tz3_n), .trip_zone_four_n(tz4_n), .serial_b_transmit(sb_tx),
        .serial_b_receive(sb_rx), .buffered_port_b_tx_frame_sync_drv(fs_drv),
        .buffered_port_b_tx_frame_sync_in(fs_in), .buffered_port_b_tx_clock_drv(ck_drv),
        .buffered_port_b_tx_clock_in(ck_in), .xmi_access_busy(busy), .xmi_access_pending(pend),
        .xmi_hold_draining(draining), .xmi_bus_tristate(tristate), .gpio_in_level(gpio_lvl));

    pamx_hold_master u_master (.clk(clk), .nrst(nrst), .want_bus(want), .grant_n(lvl15),
        .hold_req_n(hold_req_n), .ext_bus_en(ext_bus_en));

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard, far above the roughly 120 cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One-cycle write; the model only takes mux writes while unlocked
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a == `PAMX_OFS_MUX && unlock) mdl_mux = d;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask

    initial begin
        {nrst, reg_wr, reg_rd, unlock, p15_ext, p13_ext, sb_tx, busy, pend, want} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        mdl_mux = '0;
        fs_drv = '0;
        ck_drv = '0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        // Reset leaves every select on general I/O with pins released
        rd(`PAMX_OFS_MUX);
        chk(rd_val, 32'h0000_0000);
        chk({p15_drv, p14_drv, p13_drv}, 32'h0000_0000);
        $display("test reset done");

        // Locked write must not land, unlocked one must; unmapped place stays empty
        wr(`PAMX_OFS_MUX, $random(seed));
        rd(`PAMX_OFS_MUX);
        chk(rd_val, mdl_mux);
        @(posedge clk);
        unlock <= 1'b1;
        wr(`PAMX_OFS_MUX, $random(seed));
        rd(`PAMX_OFS_MUX);
        chk(rd_val, mdl_mux);
        wr(8'h14, 32'hffff_ffff);
        rd(8'h14);
        chk(rd_val, 32'h0000_0000);
        $display("test protection done");

        // Every non-hold code on pins 15 and 14 with random peripheral drive
        for (int c = 0; c < 4; c++) begin
            if (c == 1) continue;
            wr(`PAMX_OFS_MUX, {2'(c), 2'(c), 28'h000_0000});
            @(posedge clk);
            p15_ext <= 1'($random(seed));
            p13_ext <= 1'($random(seed));
            sb_tx <= 1'($random(seed));
            fs_drv <= 2'($random(seed));
            ck_drv <= 2'($random(seed));
            step(3);
            chk(sb_rx, c == 2 ? lvl15 : 1'b1);
            chk(fs_in, c == 3 ? lvl15 : 1'b0);
            chk(ck_in, c == 3 ? lvl14 : 1'b0);
            chk(p15_drv, c == 3 ? fs_drv : 2'b00);
            chk(p14_drv, c == 3 ? ck_drv : (c == 2 ? {sb_tx, 1'b1} : 2'b00));
            chk(gpio_lvl, {lvl15, lvl14, lvl13});
        end
        $display("test routing done");

        // Reserved pin 13 code keeps the pin undriven and is flagged
        wr(`PAMX_OFS_MUX, 32'h0400_0000);
        rd(`PAMX_OFS_STAT);
        step(1);
        chk(p13_drv, 2'b00);
        chk(rd_val[`PAMX_STAT_RSVD], 1'b1);
        $display("test reserved done");

        // General I/O: direction and data registers drive all three pins and read back
        wr(`PAMX_OFS_MUX, 32'h0000_0000);
        gp_dir = 3'($random(seed));
        gp_dat = 3'($random(seed));
        wr(`PAMX_OFS_DIR, {16'h0000, gp_dir, 13'h0000});
        wr(`PAMX_OFS_DATA, {16'h0000, gp_dat, 13'h0000});
        step(2);
        chk({p15_drv, p14_drv, p13_drv}, {gp_dat[2], gp_dir[2], gp_dat[1], gp_dir[1], gp_dat[0], gp_dir[0]});
        rd(`PAMX_OFS_DIR);
        chk(rd_val, {16'h0000, gp_dir, 13'h0000});
        rd(`PAMX_OFS_DATA);
        chk(rd_val, {16'h0000, gp_dat, 13'h0000});
        wr(`PAMX_OFS_DIR, 32'h0000_0000);
        $display("test general io done");

        // Pin 15 as trip input is ignored until software enables it
        wr(`PAMX_OFS_MUX, 32'h5000_0000);
        @(posedge clk);
        p15_ext <= 1'b0;
        step(3);
        chk(tz4_n, 1'b1);
        wr(`PAMX_OFS_CTRL, 32'h0000_0004);
        step(3);
        chk(tz4_n, 1'b0);
        // Hold disabled: a low request trips zone three but leaves the bus alone
        wr(`PAMX_OFS_CTRL, 32'h0000_0003);
        @(posedge clk);
        want <= 1'b1;
        step(6);
        chk(tristate, 1'b0);
        chk(tz3_n, 1'b0);
        rd(`PAMX_OFS_CTRL);
        chk(rd_val, 32'h0000_0003);
        @(posedge clk);
        want <= 1'b0;
        $display("test trip done");

        // Hold waits for busy and pending accesses, then grants on pin 15
        wr(`PAMX_OFS_DIR, 32'h0000_8000);
        wr(`PAMX_OFS_CTRL, 32'h0000_0000);
        @(posedge clk);
        busy <= 1'b1;
        want <= 1'b1;
        step(5);
        chk(draining, 1'b1);
        chk(tristate, 1'b0);
        chk(ext_bus_en, 1'b0);
        @(posedge clk);
        busy <= 1'b0;
        pend <= 1'b1;
        step(3);
        chk(tristate, 1'b0);
        @(posedge clk);
        pend <= 1'b0;
        step(4);
        chk(tristate, 1'b1);
        chk(lvl15, 1'b0);
        chk(ext_bus_en, 1'b1);
        rd(`PAMX_OFS_STAT);
        chk(rd_val[`PAMX_STAT_REQ:`PAMX_STAT_GRANT], 2'b11);
        @(posedge clk);
        want <= 1'b0;
        step(4);
        chk(tristate, 1'b0);
        chk(lvl15, 1'b1);
        $display("test hold done");

        // Reset in mid-hold drops the grant and returns every select to general I/O
        @(posedge clk);
        want <= 1'b1;
        step(8);
        chk(tristate, 1'b1);
        @(posedge clk);
        nrst <= 1'b0;
        mdl_mux = 32'h0000_0000;
        step(2);
        chk(tristate, 1'b0);
        chk(p15_drv, 2'b00);
        @(posedge clk);
        nrst <= 1'b1;
        want <= 1'b0;
        rd(`PAMX_OFS_MUX);
        chk(rd_val, mdl_mux);
        chk(ext_bus_en, 1'b0);
        $display("test mid reset done");
        complete_run();
    end
endmodule // pamx_mux_test
`default_nettype wire
